// ### shared/imst_cfg.svh
`ifndef IMST_CFG_SVH
`define IMST_CFG_SVH

// Serial frame shape
`define IMST_WORD_BITS      16
`define IMST_BURST_CMD      16'h3e00
`define IMST_ADDR_MSB       14
`define IMST_ADDR_LSB       8
`define IMST_RW_BIT         15
// Output registers shifted out in a burst, word addresses 0x02..0x2a step 2
`define IMST_BURST_FIRST    7'h02
`define IMST_BURST_LAST     7'h2a
`define IMST_NUM_REGS       64

// Timing, figures as printed
`define IMST_CLK_MHZ        125
`define IMST_SYNC_TO_DR_US  600
`define IMST_SYNC_TO_DR_CYC (`IMST_SYNC_TO_DR_US * `IMST_CLK_MHZ)
`define IMST_INT_PERIOD_CYC 152588
`define IMST_DR_PULSE_US    1
`define IMST_DR_PULSE_CYC   (`IMST_DR_PULSE_US * `IMST_CLK_MHZ)

`endif

// ### shared/imst_pkg.sv
package imst_pkg;
  typedef enum logic [1:0] {
    IMST_IDLE,
    IMST_WAIT,
    IMST_PULSE
  } imst_smp_t;

  typedef logic [15:0] imst_word_t;
endpackage

// ### verilog/imst_sync2.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for levels from outside the ref_clk domain
module imst_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } imst_s2_t;

  imst_s2_t st_ff;
  imst_s2_t nxt_st;

  // Only the second stage is visible outside
  always_comb
  begin
    nxt_st.meta = din;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign dout = st_ff.sync;
endmodule

// ### verilog/imst_sensor_port.sv
`timescale 1ns/1ps
`include "imst_cfg.svh"
// Operation
// - Output bit changes only on falling clock
// - Input bit sampled on rising clock
// - Burst words follow without idle gap
// - Data ready follows sync by 600 us
// - Shared pin: general io or sync
// - Clock idles high, MSB first, 16 bits
// - Read answer appears in next transfer
// - Command 0x3e00 bursts all output registers
// - Data ready pulses per new sample
module imst_sensor_port
  import imst_pkg::*;
#(
  parameter int SYNC_TO_DR_CYC  = `IMST_SYNC_TO_DR_CYC,
  parameter int INT_PERIOD_CYC  = `IMST_INT_PERIOD_CYC,
  parameter int DR_PULSE_CYC    = `IMST_DR_PULSE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                spi_clk,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_din,
  output logic                     spi_dout,
  input  wire logic                sync_mode_sel,
  input  wire logic                sync_clock_input_pin_in,
  output logic                     sync_clock_input_pin_out,
  output logic                     sync_clock_input_pin_oe,
  input  wire logic                gpio_out_val,
  input  wire logic                gpio_out_en,
  output logic                     gpio_in_val,
  input  wire imst_pkg::imst_word_t sample_data [`IMST_NUM_REGS],
  output logic                     sample_req,
  output logic                     data_ready_pin
);
  import imst_pkg::*;

  // ---------------- Sample timing, ref_clk domain ----------------
  typedef struct packed {
    imst_smp_t   st;
    logic [31:0] cnt;
    logic [31:0] per;
    logic        sync_prev;
    logic        dr;
    logic        req;
    logic        snap_tgl;
  } imst_core_t;

  imst_core_t core_ff;
  imst_core_t nxt_core;
  logic       sync_s;
  logic       pin_s;

  // Pin passes two flops before any logic reads it
  imst_sync2 #(
    .W (1)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .din     (sync_clock_input_pin_in),
    .dout    (pin_s)
  );

  // Pin is an input in sync mode, else a general io
  assign sync_clock_input_pin_oe  = !sync_mode_sel && gpio_out_en;
  assign sync_clock_input_pin_out = gpio_out_val;
  assign gpio_in_val              = pin_s;
  assign sync_s                   = sync_mode_sel && pin_s;

  // Start a sample on sync rise or internal timer, flag ready later
  always_comb
  begin
    nxt_core           = core_ff;
    nxt_core.sync_prev = sync_s;
    nxt_core.req       = 1'b0;
    nxt_core.per       = core_ff.per + 32'h1;
    if (!sync_mode_sel && core_ff.per >= 32'(INT_PERIOD_CYC - 1))
    begin
      nxt_core.per = '0;
      nxt_core.req = 1'b1;
    end
    case (core_ff.st)
      IMST_IDLE:
      begin
        nxt_core.dr = 1'b0;
        if (sync_s && !core_ff.sync_prev)
        begin
          nxt_core.st  = IMST_WAIT;
          nxt_core.cnt = '0;
          nxt_core.req = 1'b1;
        end
        else if (nxt_core.req)
        begin
          // Internal sampling: conversion assumed instant
          nxt_core.st       = IMST_PULSE;
          nxt_core.cnt      = '0;
          nxt_core.snap_tgl = !core_ff.snap_tgl;
        end
      end
      IMST_WAIT:
      begin
        nxt_core.cnt = core_ff.cnt + 32'h1;
        if (core_ff.cnt >= 32'(SYNC_TO_DR_CYC - 1))
        begin
          nxt_core.st       = IMST_PULSE;
          nxt_core.cnt      = '0;
          nxt_core.snap_tgl = !core_ff.snap_tgl;
        end
      end
      IMST_PULSE:
      begin
        nxt_core.dr  = 1'b1;
        nxt_core.cnt = core_ff.cnt + 32'h1;
        // Pulse stands a full DR_PULSE_CYC cycles once high
        if (core_ff.cnt >= 32'(DR_PULSE_CYC))
        begin
          nxt_core.st = IMST_IDLE;
          nxt_core.dr = 1'b0;
        end
      end
      default:
        nxt_core.st = IMST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      core_ff <= '0;
    else
      core_ff <= nxt_core;
  end

  assign data_ready_pin = core_ff.dr;
  assign sample_req     = core_ff.req;

  // Snapshot of output registers; updated only while the port is idle
  // so a read never mixes two samples. Trade-off: a sample that arrives
  // while chip select is low is dropped, not applied when it rises.
  imst_word_t snap_ff [`IMST_NUM_REGS];
  logic [2:0] tgl_ff;
  logic [1:0] csi_ff;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tgl_ff <= '0;
      csi_ff <= 2'h3;
    end
    else
    begin
      tgl_ff <= {tgl_ff[1:0], core_ff.snap_tgl};
      csi_ff <= {csi_ff[0], spi_cs_n};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (tgl_ff[2] != tgl_ff[1] && csi_ff[1])
      snap_ff <= sample_data;
  end

  // ---------------- Serial port, spi_clk domain ----------------
  // Mode 3: clock idles high, capture on rising, launch on falling
  typedef struct packed {
    logic [3:0]  bitc;
    imst_word_t  rx;
    logic        burst;
    logic        have;
  } imst_rx_t;

  imst_rx_t    rx_ff;
  imst_rx_t    nxt_rx;
  imst_word_t  tx_ff;
  imst_word_t  cmd_w;
  logic [6:0]  nxt_addr;
  logic [6:0]  addr_ff;

  assign cmd_w = {rx_ff.rx[14:0], spi_din};

  // Capture each input bit on the rising edge, MSB first
  always_comb
  begin
    nxt_rx      = rx_ff;
    nxt_rx.rx   = cmd_w;
    nxt_rx.bitc = rx_ff.bitc + 4'h1;
    nxt_rx.have = 1'b0;
    nxt_addr    = addr_ff;
    if (rx_ff.bitc == 4'(`IMST_WORD_BITS - 1))
    begin
      nxt_rx.have = 1'b1;
      if (cmd_w == `IMST_BURST_CMD)
      begin
        nxt_rx.burst = 1'b1;
        nxt_addr     = `IMST_BURST_FIRST;
      end
      else if (rx_ff.burst && addr_ff < `IMST_BURST_LAST)
        nxt_addr = addr_ff + 7'h2;
      else if (!cmd_w[`IMST_RW_BIT])
      begin
        nxt_rx.burst = 1'b0;
        nxt_addr     = cmd_w[`IMST_ADDR_MSB:`IMST_ADDR_LSB];
      end
      else
        nxt_rx.burst = 1'b0;
    end
  end

  // Chip select high ends any frame; burst ends with it
  always_ff @(posedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      rx_ff.bitc  <= '0;
      rx_ff.rx    <= '0;
      rx_ff.have  <= 1'b0;
      rx_ff.burst <= 1'b0;
    end
    else
    begin
      rx_ff.bitc  <= nxt_rx.bitc;
      rx_ff.rx    <= nxt_rx.rx;
      rx_ff.have  <= nxt_rx.have;
      rx_ff.burst <= nxt_rx.burst;
    end
  end

  // Address survives chip select so single reads chain across frames
  always_ff @(posedge spi_clk)
  begin
    addr_ff <= nxt_addr;
  end

  // Launch on falling edge: load a word at the start of each word, else shift
  always_ff @(negedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
      tx_ff <= '0;
    else if (rx_ff.bitc == 4'h0)
      tx_ff <= snap_ff[addr_ff[6:1]];
    else
      tx_ff <= {tx_ff[14:0], 1'b0};
  end

  // First bit launches on the first falling edge after select
  assign spi_dout = tx_ff[15];
endmodule

// ### bench/imst_checker.sv
`timescale 1ns/1ps
// Link edge, sample pacing and shared pin checks
module imst_checker #(
  parameter int SYNC_TO_DR_CYC = 1,
  parameter int DR_PULSE_CYC   = 1
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic spi_clk,
  input logic spi_cs_n,
  input logic spi_dout,
  input logic sync_mode_sel,
  input logic sync_clock_input_pin_in,
  input logic sync_clock_input_pin_out,
  input logic sync_clock_input_pin_oe,
  input logic gpio_out_val,
  input logic gpio_out_en,
  input logic gpio_in_val,
  input logic sample_req,
  input logic data_ready_pin
);
  // Slack covers the pin synchroniser and edge detect
  localparam int SLO = SYNC_TO_DR_CYC;
  localparam int SHI = SYNC_TO_DR_CYC + 10;
  localparam int DRW = DR_PULSE_CYC;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_dout; !spi_cs_n && $changed(spi_dout) |-> !spi_clk; endproperty
  a_dout: assert property (p_dout) else $error("dout edge");
  property p_sync;
    sync_mode_sel && $rose(sync_clock_input_pin_in)
      |-> ##[SLO:SHI] $rose(data_ready_pin);
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency");
  property p_wid; $rose(data_ready_pin) |-> ##[DRW:DRW] $fell(data_ready_pin);
  endproperty
  a_wid: assert property (p_wid) else $error("ready width");
  property p_req;
    !sync_mode_sel && sample_req |-> ##[1:3] $rose(data_ready_pin);
  endproperty
  a_req: assert property (p_req) else $error("ready late");
  property p_one; sample_req |=> !sample_req; endproperty
  a_one: assert property (p_one) else $error("req width");
  property p_oe;
    sync_clock_input_pin_oe == (!sync_mode_sel && gpio_out_en);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_out;
    sync_clock_input_pin_oe |-> sync_clock_input_pin_out == gpio_out_val;
  endproperty
  a_out: assert property (p_out) else $error("pin value");
  property p_gin;
    $stable(sync_clock_input_pin_in) [*5]
      |-> gpio_in_val == sync_clock_input_pin_in;
  endproperty
  a_gin: assert property (p_gin) else $error("pin readback");
  c_sync: cover property (sync_mode_sel && $rose(data_ready_pin));
  c_req: cover property (sample_req);
  c_link: cover property (!spi_cs_n && $fell(spi_clk));
endmodule

bind imst_sensor_port imst_checker #(
  .SYNC_TO_DR_CYC(SYNC_TO_DR_CYC),
  .DR_PULSE_CYC(DR_PULSE_CYC)
) u_chk (
  .ref_clk, .sys_rst, .spi_clk, .spi_cs_n, .spi_dout, .sync_mode_sel,
  .sync_clock_input_pin_in, .sync_clock_input_pin_out,
  .sync_clock_input_pin_oe, .gpio_out_val, .gpio_out_en, .gpio_in_val,
  .sample_req, .data_ready_pin
);

// ### bench/imst_spi_host.sv
`timescale 1ns/1ps
// Host side of the link; clock parked high between frames
module imst_spi_host (
  output logic spi_clk = 1,
  output logic spi_cs_n = 1,
  output logic spi_din = 0,
  input  logic spi_dout
);
  realtime t0 = -1e5;
  // Fresh frames keep gap and spacing, burst words only one clock
  task automatic xfer(input logic [15:0] tx, input bit keep,
                      output logic [15:0] rx);
    if (spi_cs_n)
    begin
      #9000;
      while ($realtime - t0 < 40000) #100;
    end
    else
      #125;
    t0 = $realtime;
    spi_cs_n = 0;
    for (int i = 15; i >= 0; i--)
    begin
      #62.5 spi_clk = 0;
      spi_din = tx[i];
      #62.5 spi_clk = 1;
      rx[i] = spi_dout;
    end
    #62.5 spi_cs_n = !keep;
    spi_din = !spi_din; // Released line must not hold a stale bit
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import imst_pkg::*;
  logic        ref_clk = 0;
  logic        sys_rst = 1;
  logic        sync_mode_sel = 0;
  logic        gpio_out_val = 0;
  logic        gpio_out_en = 0;
  logic        ext = 0;
  logic        q = 0;
  imst_word_t  sample_data [64];
  logic        spi_clk, spi_cs_n, spi_din, spi_dout, sample_req, gpio_in_val;
  logic        sync_clock_input_pin_out, sync_clock_input_pin_oe;
  logic        data_ready_pin;
  logic [15:0] rx;
  logic [6:0]  a, p;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n;
  int          m = 0;
  // Shared pin: device drives when enabled, else the bench
  wire         pin = sync_clock_input_pin_oe ? sync_clock_input_pin_out : ext;
  always #4 ref_clk = ~ref_clk;
  imst_spi_host host (.spi_clk, .spi_cs_n, .spi_din, .spi_dout);
  imst_sensor_port #(
    .SYNC_TO_DR_CYC(200),
    .INT_PERIOD_CYC(300),
    .DR_PULSE_CYC(4)
  ) dut (
    .ref_clk, .sys_rst, .spi_clk, .spi_cs_n, .spi_din, .spi_dout,
    .sync_mode_sel, .sync_clock_input_pin_in(pin), .sync_clock_input_pin_out,
    .sync_clock_input_pin_oe, .gpio_out_val, .gpio_out_en, .gpio_in_val,
    .sample_data, .sample_req, .data_ready_pin
  );
  function automatic imst_word_t exp_rd(input logic [6:0] ad);
    return sample_data[ad[6:1]];
  endfunction
  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: pacing, pin, link, sync
  initial
  begin
    void'($urandom(90));
    foreach (sample_data[i]) sample_data[i] = imst_word_t'($urandom);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    repeat (1000)
    begin
      @(posedge ref_clk);
      #1;
      n += data_ready_pin && !q;
      m += sample_req;
      q = data_ready_pin;
    end
    chk("ready_count", n, 3);
    chk("req_count", m, 3);
    $display("pacing end");
    repeat (6)
    begin
      @(posedge ref_clk);
      {gpio_out_en, gpio_out_val, ext} <= 3'($urandom);
      repeat (5) @(posedge ref_clk);
      #1;
      chk("pin_oe", sync_clock_input_pin_oe, gpio_out_en);
      chk("pin_in", gpio_in_val, pin);
    end
    $display("pin end");
    // Reads answer one word late; edge addresses first
    for (int i = 0; i < 4; i++)
    begin
      a = i == 0 ? 7'h7e : i == 1 ? 7'h00 : 7'($urandom_range(63) << 1);
      host.xfer({1'b0, a, 8'h00}, 0, rx);
      if (i > 0) chk("read", rx, exp_rd(p));
      p = a;
    end
    host.xfer(16'h3e00, 1, rx);
    chk("read", rx, exp_rd(p));
    for (int k = 1; k < 22; k++)
    begin
      host.xfer(16'h0000, k < 21, rx);
      chk("burst", rx, sample_data[k]);
    end
    $display("link end");
    // Mid-run reset: ready and request outputs must be low two cycles into reset
    @(posedge ref_clk);
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("rst_ready", data_ready_pin, 0);
    chk("rst_req", sample_req, 0);
    @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    sync_mode_sel <= 1;
    ext <= 0;
    gpio_out_en <= 1;
    repeat (12500) @(posedge ref_clk);
    chk("pin_oe", sync_clock_input_pin_oe, 0);
    ext <= 1;
    for (n = 0; n < 999 && !data_ready_pin; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk("sync_delay", n > 200 && n < 212, 1);
    repeat (625) @(posedge ref_clk);
    ext <= 0;
    $display("sync end");
    finish_test;
  end
endmodule
